// file: design/tsw_sequencer.sv
// time-state sequencer with wait hold, maintenance stop and microbreak
// assumes one 200 MHz clock, APB master, host handshake synchronous
// Summary of operation
// - sequencing derives from 20 MHz base tick
// - four time states, each with buffered copies
// - pause flag holds between b and c
// - resume enable restarts on next tick
// - manual continue clears maintenance hold flag
// - maint match or single step sets hold
// - strobes in second half of a, b, d
// - flag match of address and microbreak
// - maint microbreak traps to d, interrupts
// - match copy delayed one rom state
// - trap force suppresses address, enables trap
// - instruction load pulses instruction start clear
// - maintenance may select variable clock
// - wait status flag and wait indicator
// - ack wait holds, requests trap, ack releases
//
// The address map and the APB interface to the registers were left to the implementer.
module tsw_sequencer
  import tsw_pkg::*;
#(
  parameter int                 AW        = ADDR_W,
  parameter logic [ADDR_W-1:0]  TRAP_ADDR = 9'h004
) (
  input  wire logic          clk,            // 200 MHz clock
  input  wire logic          rst,            // sync reset, high
  input  wire logic          psel,           // apb select
  input  wire logic          penable,        // apb access phase
  input  wire logic          pwrite,         // apb direction
  input  wire logic [11:0]   paddr,          // apb byte address
  input  wire logic [31:0]   pwdata,         // apb write data
  output logic      [31:0]   prdata,         // apb read data
  output logic               pready,         // apb ready
  output logic               pslverr,        // apb error
  input  wire logic [AW-1:0] romNextAddr,    // next control address
  input  wire logic          romSync,        // rom sync command
  input  wire logic          minusZeroTrap,  // minus zero trap coming
  input  wire logic          awaitAck,       // await ack command
  input  wire logic          hostAck,        // host acknowledge
  input  wire logic          manualContinue, // maintenance continue
  input  wire logic          readyState,     // sequencer in ready
  input  wire logic          irLoad,         // instruction reg load
  output tsw_states_t        timeState,      // decoded time states
  output tsw_states_t        timeStateDupA,  // buffered copy a
  output tsw_states_t        timeStateDupB,  // buffered copy b
  output logic               firstStrobe,    // second half of a
  output logic               secondStrobe,   // second half of b
  output logic               fourthStrobe,   // second half of d
  output logic               waitLamp,       // wait indicator
  output logic               coprocTrapReq,  // trap request to host
  output logic               syncFlag,       // sync flag
  output logic               matchSync,      // delayed match
  output logic [AW-1:0]      romAddrOut,     // address or trap addr
  output logic               trapForceN,     // trap force, low
  output logic               instStartClr,   // instruction start pulse
  output logic               irq             // level interrupt
);
  // ****************************************
  // registers and internal state
  // ****************************************
  logic [4:0]       ctrlQ;
  logic [DIV_W-1:0] varDivQ;
  logic [AW-1:0]    ubrkQ;
  logic [AW-1:0]    crarQ;
  logic [EV_W-1:0]  istatQ, ienQ, evSet;
  tsw_seq_t         seqQ, seqD;
  logic             pauseQ, maintHoldQ, ubTrapQ, waitQ;
  logic             baseTick, baseMid, varTick, varMid, tick, mid;
  logic             match, matchDly, maint, wrEn, rdEn, mapped;
  logic             holdHit, trapHit, startEn;
  logic [DIV_W-1:0] varPeriod;

  assign maint = ctrlQ[CTRL_MAINT];
  assign wrEn  = psel && penable && pwrite;
  assign rdEn  = psel && !penable && !pwrite;

  // ****************************************
  // time base
  // ****************************************
  assign varPeriod = (varDivQ < VAR_DIV_MIN) ? VAR_DIV_MIN : varDivQ;

  tsw_tick_div #(.W(DIV_W)) uBaseDiv (
    .clk    (clk),
    .rst    (rst),
    .period (DIV_W'(BASE_DIV)),
    .tick   (baseTick),
    .mid    (baseMid)
  );

  tsw_tick_div #(.W(DIV_W)) uVarDiv (
    .clk    (clk),
    .rst    (rst),
    .period (varPeriod),
    .tick   (varTick),
    .mid    (varMid)
  );

  // variable clock only honoured in maintenance
  assign tick = (maint && ctrlQ[CTRL_VARCLK]) ? varTick : baseTick;
  assign mid  = (maint && ctrlQ[CTRL_VARCLK]) ? varMid : baseMid;

  tsw_ubrk_match #(.AW(AW)) uMatch (
    .clk      (clk),
    .rst      (rst),
    .addr     (crarQ),
    .brk      (ubrkQ),
    .romEnd   (tick && seqQ == ST_D),
    .match    (match),
    .matchDly (matchDly)
  );

  // ****************************************
  // sequencer
  // ****************************************
  assign holdHit = maint && (match && ctrlQ[CTRL_HALTM] || ctrlQ[CTRL_SSTEP]);
  assign trapHit = maint && !readyState && match && !ubTrapQ;
  assign startEn = !pauseQ && !maintHoldQ;

  always_comb begin
    seqD = seqQ;
    if (tick) begin
      if (trapHit && seqQ != ST_WAIT) begin
        seqD = ST_D;
      end else begin
        case (seqQ)
          ST_A:    seqD = ST_B;
          ST_B:    seqD = (pauseQ || maintHoldQ) ? ST_WAIT : ST_C;
          ST_C:    seqD = ST_D;
          ST_D:    seqD = ST_A;
          ST_WAIT: seqD = startEn ? ST_C : ST_WAIT;
          default: seqD = ST_A;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seqQ <= ST_A;
      waitQ <= 1'b0;
    end else begin
      seqQ <= seqD;
      waitQ <= (seqD == ST_WAIT);
    end
  end

  // outputs decoded from next state so they line up with seqQ
  always_ff @(posedge clk) begin
    if (rst) begin
      timeState <= '0;
      timeStateDupA <= '0;
      timeStateDupB <= '0;
      waitLamp <= 1'b0;
    end else begin
      timeState <= '{seqD == ST_A, seqD == ST_B, seqD == ST_C, seqD == ST_D};
      timeStateDupA <= '{seqD == ST_A, seqD == ST_B, seqD == ST_C, seqD == ST_D};
      timeStateDupB <= '{seqD == ST_A, seqD == ST_B, seqD == ST_C, seqD == ST_D};
      waitLamp <= (seqD == ST_WAIT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      firstStrobe <= 1'b0;
      secondStrobe <= 1'b0;
      fourthStrobe <= 1'b0;
    end else begin
      firstStrobe <= mid && seqQ == ST_A;
      secondStrobe <= mid && seqQ == ST_B;
      fourthStrobe <= mid && seqQ == ST_D;
    end
  end

  // ****************************************
  // hold flags
  // ****************************************
  // set wins over clear so a late command is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      pauseQ <= 1'b0;
    end else if (awaitAck) begin
      pauseQ <= 1'b1;
    end else if (hostAck) begin
      pauseQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      maintHoldQ <= 1'b0;
    end else if (mid && seqQ == ST_A && holdHit) begin
      maintHoldQ <= 1'b1;
    end else if (manualContinue || (wrEn && paddr == CTRL_OFS && pwdata[CTRL_CONT])) begin
      maintHoldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      coprocTrapReq <= 1'b0;
    end else begin
      coprocTrapReq <= pauseQ && seqQ == ST_WAIT;
    end
  end

  // ****************************************
  // control address, microbreak trap
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      crarQ <= '0;
    end else if (tick && seqQ == ST_D) begin
      crarQ <= romNextAddr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ubTrapQ <= 1'b0;
    end else if (tick && trapHit && seqQ != ST_WAIT) begin
      ubTrapQ <= 1'b1;
    end else if (tick && seqQ == ST_D) begin
      ubTrapQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      romAddrOut <= '0;
      trapForceN <= 1'b1;
      matchSync <= 1'b0;
    end else begin
      romAddrOut <= ubTrapQ ? TRAP_ADDR : crarQ;
      trapForceN <= !ubTrapQ;
      matchSync <= matchDly;
    end
  end

  // ****************************************
  // sync flag, instruction start
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      syncFlag <= 1'b0;
    end else if (seqQ == ST_B && (romSync || minusZeroTrap)) begin
      syncFlag <= 1'b1;
    end else if (irLoad || hostAck) begin
      syncFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      instStartClr <= 1'b0;
    end else begin
      instStartClr <= irLoad;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    evSet = '0;
    evSet[EV_WAIT] = (seqD == ST_WAIT) && (seqQ != ST_WAIT);
    evSet[EV_UBRK] = tick && trapHit && seqQ != ST_WAIT;
    evSet[EV_ACK]  = awaitAck && !pauseQ;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      istatQ <= '0;
    end else begin
      istatQ <= evSet | (istatQ & ~((wrEn && paddr == ICLR_OFS) ? pwdata[EV_W-1:0] : '0));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istatQ & ienQ);
    end
  end

  // ****************************************
  // apb slave: zero wait states
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlQ <= CTRL_RST;
      varDivQ <= VAR_DIV_RST;
      ubrkQ <= UBRK_RST;
      ienQ <= '0;
    end else if (wrEn) begin
      case (paddr)
        CTRL_OFS: ctrlQ <= {1'b0, pwdata[3:0]};
        VDIV_OFS: varDivQ <= pwdata[DIV_W-1:0];
        UBRK_OFS: ubrkQ <= pwdata[AW-1:0];
        IEN_OFS:  ienQ <= pwdata[EV_W-1:0];
        default:  ;
      endcase
    end
  end

  always_comb begin
    case (paddr)
      CTRL_OFS, VDIV_OFS, UBRK_OFS, STAT_OFS,
      ISTAT_OFS, IEN_OFS, ICLR_OFS, CONTROL_ADDRESS_REG_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rdEn) begin
        case (paddr)
          CTRL_OFS:  prdata <= 32'(ctrlQ);
          VDIV_OFS:  prdata <= 32'(varDivQ);
          UBRK_OFS:  prdata <= 32'(ubrkQ);
          STAT_OFS:  prdata <= 32'({matchDly, match, maintHoldQ, pauseQ, waitQ,
                                    timeState});
          ISTAT_OFS: prdata <= 32'(istatQ);
          IEN_OFS:   prdata <= 32'(ienQ);
          CONTROL_ADDRESS_REG_OFS:  prdata <= 32'(crarQ);
          default:   prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : tsw_sequencer

// file: pkg/tsw_pkg.sv
// time-state wait sequencer: shared constants and types
// assumes a single 200 MHz clock and an APB register port
package tsw_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ      = 200;
  localparam int BASE_OSC_MHZ = 20;
  localparam int BASE_DIV     = CLK_MHZ / BASE_OSC_MHZ;
  localparam int DIV_W        = 8;
  localparam logic [DIV_W-1:0] VAR_DIV_RST = 8'h14;
  localparam logic [DIV_W-1:0] VAR_DIV_MIN = 8'h02;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] VDIV_OFS   = 12'h004;
  localparam logic [11:0] UBRK_OFS   = 12'h008;
  localparam logic [11:0] STAT_OFS   = 12'h00C;
  localparam logic [11:0] ISTAT_OFS  = 12'h010;
  localparam logic [11:0] IEN_OFS    = 12'h014;
  localparam logic [11:0] ICLR_OFS   = 12'h018;
  localparam logic [11:0] CONTROL_ADDRESS_REG_OFS   = 12'h01C;
  // CTRL fields
  localparam int CTRL_MAINT  = 0;
  localparam int CTRL_VARCLK = 1;
  localparam int CTRL_HALTM  = 2;
  localparam int CTRL_SSTEP  = 3;
  localparam int CTRL_CONT   = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // interrupt event bits
  localparam int EV_WAIT = 0;
  localparam int EV_UBRK = 1;
  localparam int EV_ACK  = 2;
  localparam int EV_W    = 3;
  localparam int ADDR_W  = 9;
  localparam logic [ADDR_W-1:0] UBRK_RST = 9'h1FF;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } tsw_states_t;
  typedef enum logic [2:0] {ST_A, ST_B, ST_C, ST_D, ST_WAIT} tsw_seq_t;
endpackage : tsw_pkg

// file: design/tsw_tick_div.sv
// clock divider: one-cycle end-of-period tick and mid-period pulse
// assumes period >= 2; period change takes effect in the current period
module tsw_tick_div
  import tsw_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst,    // sync reset
  input  wire logic [W-1:0] period, // cycles per tick
  output logic              tick,   // last cycle of period
  output logic              mid     // cycle before second half
);
  logic [W-1:0] cntQ;

  always_ff @(posedge clk) begin
    if (rst || cntQ >= period - W'(1)) begin
      cntQ <= '0;
    end else begin
      cntQ <= cntQ + W'(1);
    end
  end

  assign tick = !rst && (cntQ == period - W'(1));
  // one early so a registered strobe still lands inside the state, even at period 2
  assign mid  = !rst && (cntQ == (period >> 1) - W'(1));
endmodule : tsw_tick_div

// file: design/tsw_ubrk_match.sv
// microbreak comparator with a one-rom-state delayed copy
// assumes romEnd pulses once per control rom cycle
module tsw_ubrk_match
  import tsw_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          clk,     // system clock
  input  wire logic          rst,     // sync reset
  input  wire logic [AW-1:0] addr,    // control address register
  input  wire logic [AW-1:0] brk,     // microbreak address
  input  wire logic          romEnd,  // end of a rom state
  output logic               match,   // registered compare
  output logic               matchDly // match one rom state later
);
  always_ff @(posedge clk) begin
    if (rst) begin
      match <= 1'b0;
    end else begin
      match <= (addr == brk);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      matchDly <= 1'b0;
    end else if (romEnd) begin
      matchDly <= match;
    end
  end
endmodule : tsw_ubrk_match

// file: verif/tsw_sequencer_chk.sv
// checker for tsw_sequencer, bound to its top-level ports
// assumes one clk domain with a synchronous active-high rst
module tsw_seq_chk
  import tsw_pkg::*;
#(
  parameter int                AW        = ADDR_W,
  parameter logic [ADDR_W-1:0] TRAP_ADDR = 9'h004
) (
  input wire logic          clk,           // clock
  input wire logic          rst,           // sync reset
  input wire logic          romSync,       // sync command
  input wire logic          hostAck,       // host acknowledge
  input wire logic          irLoad,        // instruction load
  input wire tsw_states_t   timeState,     // time states
  input wire tsw_states_t   timeStateDupA, // copy a
  input wire tsw_states_t   timeStateDupB, // copy b
  input wire logic          firstStrobe,   // strobe in a
  input wire logic          secondStrobe,  // strobe in b
  input wire logic          fourthStrobe,  // strobe in d
  input wire logic          waitLamp,      // wait indicator
  input wire logic          coprocTrapReq, // trap request
  input wire logic          syncFlag,      // sync flag
  input wire logic [AW-1:0] romAddrOut,    // address out
  input wire logic          trapForceN,    // trap force, low
  input wire logic          instStartClr   // start clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // sequencing, wait and trap relations
  // ****************************************
  a_state_onehot: assert property ($onehot0(timeState))
    else $error("time states not one-hot");
  a_dup_copies: assert property (timeStateDupA == timeState && timeStateDupB == timeState)
    else $error("buffered state copy differs");
  a_c_then_d: assert property (timeState == 4'b0010 ##1 timeState != 4'b0010
    |-> timeState == 4'b0001)
    else $error("state c not followed by d");
  a_wait_after_b: assert property ($rose(waitLamp) |-> $past(timeState) == 4'b0100)
    else $error("wait entered outside b");
  a_wait_dark: assert property (waitLamp |-> timeState == 4'b0000)
    else $error("state lit during wait");
  a_resume_c: assert property ($fell(waitLamp) |-> timeState == 4'b0010)
    else $error("wait left to a state other than c");
  a_strobe_a: assert property (firstStrobe |-> timeState.a ##1 !firstStrobe)
    else $error("first strobe misplaced");
  a_strobe_b: assert property (secondStrobe |-> timeState.b ##1 !secondStrobe)
    else $error("second strobe misplaced");
  a_strobe_d: assert property (fourthStrobe |-> timeState.d ##1 !fourthStrobe)
    else $error("fourth strobe misplaced");
  a_start_clear: assert property ($rose(irLoad) |=> instStartClr)
    else $error("no start clear after load");
  a_trap_in_wait: assert property (coprocTrapReq |-> waitLamp)
    else $error("trap request outside wait");
  a_ack_drops: assert property (hostAck && coprocTrapReq |-> ##[1:3] !coprocTrapReq)
    else $error("trap request kept after ack");
  a_trap_addr: assert property (!trapForceN |-> romAddrOut == TRAP_ADDR)
    else $error("address not replaced during trap");
  a_sync_set: assert property (timeState.b && romSync && !irLoad && !hostAck
    |-> ##[1:3] syncFlag)
    else $error("sync flag not set in b");
endmodule : tsw_seq_chk

bind tsw_sequencer tsw_seq_chk #(.AW(AW), .TRAP_ADDR(TRAP_ADDR)) chk_u (
  .clk(clk), .rst(rst), .romSync(romSync), .hostAck(hostAck), .irLoad(irLoad),
  .timeState(timeState), .timeStateDupA(timeStateDupA), .timeStateDupB(timeStateDupB),
  .firstStrobe(firstStrobe),
  .secondStrobe(secondStrobe), .fourthStrobe(fourthStrobe), .waitLamp(waitLamp),
  .coprocTrapReq(coprocTrapReq), .syncFlag(syncFlag), .romAddrOut(romAddrOut),
  .trapForceN(trapForceN), .instStartClr(instStartClr));

// file: verif/tsw_host_model.sv
// host processor model: acknowledges coprocessor trap requests
// assumes the request is a level synchronous to clk
module tsw_host_model (
  input  wire logic       clk,     // clock
  input  wire logic       rst,     // sync reset
  input  wire logic       trapReq, // trap request
  input  wire logic [7:0] ackDly,  // cycles before ack
  output logic            hostAck  // acknowledge pulse
);
  logic [7:0] cnt_q;
  // one ack per request; 8-bit counter runs on, so it repeats only if the request is held 256 cycles past the first ack
  always_ff @(posedge clk) begin
    if (rst || !trapReq) begin
      cnt_q   <= 8'h00;
      hostAck <= 1'b0;
    end else begin
      cnt_q   <= cnt_q + 8'h01;
      hostAck <= (cnt_q == ackDly);
    end
  end
endmodule : tsw_host_model

// file: verif/tsw_sequencer_bench.sv
// self-checking bench for tsw_sequencer with a host model
// assumes APB access and 200 MHz clk; reset held four cycles
module tsw_sequencer_bench
  import tsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAMP = 0;
  localparam int TRAPN = 1;
  localparam int SYNC = 2;
  logic        clk, rst, psel, penable, pwrite, romSync, awaitAck;
  logic        manualContinue, readyState, irLoad, errv, minusZero, matchSync;
  logic        pready, pslverr, hostAck, waitLamp, coprocTrapReq, syncFlag, trapForceN, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [8:0]  romNextAddr, romAddrOut;
  logic [7:0]  ackDly;
  tsw_states_t timeState;
  int          fail_count, n_checks;

  tsw_sequencer dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .romNextAddr(romNextAddr), .romSync(romSync), .minusZeroTrap(minusZero),
    .awaitAck(awaitAck), .hostAck(hostAck), .manualContinue(manualContinue),
    .readyState(readyState), .irLoad(irLoad), .timeState(timeState), .timeStateDupA(),
    .timeStateDupB(), .firstStrobe(), .secondStrobe(), .fourthStrobe(),
    .waitLamp(waitLamp), .coprocTrapReq(coprocTrapReq), .syncFlag(syncFlag),
    .matchSync(matchSync), .romAddrOut(romAddrOut), .trapForceN(trapForceN),
    .instStartClr(), .irq(irq));
  tsw_host_model host_u (.clk(clk), .rst(rst), .trapReq(coprocTrapReq), .ackDly(ackDly),
    .hostAck(hostAck));

  // ****************************************
  // reporting, bus and wait tasks
  // ****************************************
  task close_out;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, s, x);
    end
  endtask : chk
  task tout;
    fail_count++;
    $display("ERROR %0t: wait timed out", $time);
    close_out();
  endtask : tout
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tout();
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdv, x);
    chk(32'(errv), 32'(a > CONTROL_ADDRESS_REG_OFS));
  endtask : rd
  function automatic logic [3:0] pick(input int k);
    case (k)
      LAMP: return 4'(waitLamp);
      TRAPN: return 4'(trapForceN);
      SYNC: return 4'(syncFlag);
      default: return timeState;
    endcase
  endfunction : pick
  task wfor(input int k, input logic [3:0] v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) tout();
  endtask : wfor
  task meas(input int x);
    int n;
    wfor(3, 4'b0100);
    wfor(3, 4'b1000);
    n = 0;
    while (timeState === 4'b1000 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(n, x);
  endtask : meas
  // k: 0 ack wait command, 1 manual continue, 2 instruction load
  task pulse(input int k);
    if (k == 0) awaitAck <= 1'b1;
    else if (k == 1) manualContinue <= 1'b1;
    else irLoad <= 1'b1;
    @(posedge clk);
    awaitAck <= 1'b0;
    manualContinue <= 1'b0;
    irLoad <= 1'b0;
    @(posedge clk);
  endtask : pulse

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, psel, penable, pwrite, romSync, awaitAck, manualContinue, irLoad} = 8'h80;
    {readyState, paddr, pwdata, romNextAddr, ackDly} = {1'b1, 12'h0, 32'h0, 9'h055, 8'h0};
    minusZero = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL_OFS, 32'h0);
    rd(VDIV_OFS, 32'h14);
    rd(UBRK_OFS, 32'h1FF);
    rd(12'h024, 32'h0);
    meas(BASE_DIV);
    wr(VDIV_OFS, 32'h6);
    wr(CTRL_OFS, 32'h3);
    meas(6);
    wr(CTRL_OFS, 32'h0);
    meas(BASE_DIV);
    // prompt host, interrupt masked, then unmasked and cleared
    pulse(0);
    wfor(LAMP, 1);
    wfor(LAMP, 0);
    rd(ISTAT_OFS, 32'h5);
    chk(32'(irq), 32'h0);
    wr(IEN_OFS, 32'h4);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(ICLR_OFS, 32'h7);
    rd(ISTAT_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    // slow host keeps the sequencer parked
    ackDly <= 8'h28;
    pulse(0);
    wfor(LAMP, 1);
    repeat (30) @(posedge clk);
    chk(32'(waitLamp), 32'h1);
    wfor(LAMP, 0);
    chk(32'(irq), 32'h1);
    // single rom cycle stop and manual continue
    wr(CTRL_OFS, 32'h9);
    wfor(LAMP, 1);
    rd(STAT_OFS, 32'h50);
    wr(CTRL_OFS, 32'h1);
    pulse(1);
    wfor(LAMP, 0);
    wr(ICLR_OFS, 32'h7);
    // microbreak: blocked in ready, traps otherwise, halts when asked
    wr(UBRK_OFS, 32'h55);
    meas(BASE_DIV);
    chk(32'(trapForceN), 32'h1);
    readyState <= 1'b0;
    wfor(TRAPN, 0);
    chk(32'(romAddrOut), 32'h004);
    rd(ISTAT_OFS, 32'h2);
    rd(CONTROL_ADDRESS_REG_OFS, 32'h55);
    chk(32'(matchSync), 32'h1);
    // trap loop never reaches b while the address repeats, so block it for the halt
    readyState <= 1'b1;
    wr(CTRL_OFS, 32'h5);
    wfor(LAMP, 1);
    wr(UBRK_OFS, 32'h1FF);
    wr(CTRL_OFS, 32'h1);
    pulse(1);
    wfor(LAMP, 0);
    wr(CTRL_OFS, 32'h0);
    // sync flag set in b, cleared by instruction load
    romSync <= 1'b1;
    wfor(SYNC, 1);
    romSync <= 1'b0;
    pulse(2);
    wfor(SYNC, 0);
    minusZero <= 1'b1;
    wfor(SYNC, 1);
    minusZero <= 1'b0;
    pulse(2);
    wfor(SYNC, 0);
    close_out();
  end
endmodule : tsw_sequencer_bench
